// ### rtl/hdp_pkg.sv
`default_nettype none
package hdp_pkg;
  // Widths of the host pins and of the internal word.
  localparam int          HDP_ADDR_W       = 8;
  localparam int          HDP_HALF_W       = 16;
  localparam int          HDP_WORD_W       = 32;
  localparam int          HDP_IDX_W        = 6;
  localparam int          HDP_TX_DEPTH     = 16;
  // Position of the half select in the byte address.
  localparam int          HDP_HALF_BIT     = 1;
  // Swap control value that turns the half mapping round.
  localparam logic [31:0] HDP_SWAP_PATTERN = 32'h0FFFFFFF;
  // Word indices that reach the data paths instead of the register port.
  localparam logic [5:0]  HDP_RX_DATA_IDX  = 6'h00;
  localparam logic [5:0]  HDP_TX_DATA_IDX  = 6'h01;
  // Values after reset and the answer to a broken read pair.
  localparam logic [31:0] HDP_WORD_RST     = 32'h00000000;
  localparam logic [15:0] HDP_HALF_RST     = 16'h0000;
  localparam logic [15:0] HDP_INVALID_HALF = 16'h0000;
  localparam logic [7:0]  HDP_ADDR_RST     = 8'h00;
  localparam logic [5:0]  HDP_IDX_RST      = 6'h00;

  typedef logic [HDP_HALF_W-1:0] hdp_half_t;
  typedef logic [HDP_WORD_W-1:0] hdp_word_t;
  typedef logic [HDP_IDX_W-1:0]  hdp_idx_t;
  typedef logic [HDP_ADDR_W-1:0] hdp_addr_t;

  // Selects the high or low half of a word.
  function automatic hdp_half_t hdp_pick(input hdp_word_t w, input logic hi);
    hdp_pick = hi ? w[31:16] : w[15:0];
  endfunction : hdp_pick

  // Replaces the high or low half of a word.
  function automatic hdp_word_t hdp_place(input hdp_word_t w, input hdp_half_t h,
                                          input logic hi);
    hdp_place = hi ? {h, w[15:0]} : {w[31:16], h};
  endfunction : hdp_place
endpackage : hdp_pkg
`default_nettype wire

// ### rtl/hdp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hdp_if;
  import hdp_pkg::*;
  logic      cs_n;
  logic      wr_n;
  logic      rd_n;
  hdp_addr_t addr;
  hdp_half_t host_data;
  logic      host_data_oe;
  hdp_half_t dev_data;
  logic      dev_data_oe;
  logic      ack;
  hdp_half_t bus_data;

  // Level of the shared data wire; an undriven bus reads as zero.
  assign bus_data = host_data_oe ? host_data : (dev_data_oe ? dev_data : HDP_HALF_RST);

  modport dev_mp (input cs_n, wr_n, rd_n, addr, bus_data,
                  output dev_data, dev_data_oe, ack);
  modport host_mp (output cs_n, wr_n, rd_n, addr, host_data, host_data_oe,
                   input bus_data, ack);
endinterface : hdp_if
`default_nettype wire

// ### rtl/hdp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module hdp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import hdp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic             push;
  logic             pop;

  // The extra pointer bit tells a full store from an empty one.
  assign in_ready  = (wptr_reg ^ rptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wptr_reg != rptr_reg;
  assign out_data  = mem[rptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers advance only on a completed handshake.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) rptr_reg <= rptr_reg + 1'b1;
    end
  end

  // Storage needs no reset; nothing is read before it is written.
  always_ff @(posedge clk) begin
    if (push) mem[wptr_reg[AW-1:0]] <= in_data;
  end
endmodule : hdp_fifo
`default_nettype wire

// ### rtl/hdp_device.sv
// Overview of operation
// RQ1 - Host writes a word as two halves.
// RQ2 - Host keeps word address fixed across halves.
// RQ3 - Write halves accepted in either order.
// RQ4 - Repeated write half drops the pending transfer.
// RQ5 - Host reads a word as two halves.
// RQ6 - Host keeps word address fixed across reads.
// RQ7 - Read halves allowed in either order.
// RQ8 - Repeated read half: invalid data, pairing restarts.
// RQ9 - Default mapping: select low gives bytes 1,0.
// RQ10 - Swap pattern: select low gives bytes 3,2.
// RQ11 - Mapping covers registers and both data paths.
// RQ12 - Low half leaves first, arrives first.
// RQ13 - First write half staged until its partner.
`timescale 1ns/1ps
`default_nettype none
module hdp_device (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Host pins.
  hdp_if.dev_mp                   hp,
  // Word swap control value.
  input  wire hdp_pkg::hdp_word_t swap_ctrl,
  // Register write port.
  output logic                    dw_wr_valid,
  output hdp_pkg::hdp_idx_t       dw_wr_idx,
  output hdp_pkg::hdp_word_t      dw_wr_data,
  // Register read port.
  output logic                    dw_rd_req,
  output hdp_pkg::hdp_idx_t       dw_rd_idx,
  input  wire hdp_pkg::hdp_word_t dw_rd_data,
  // Transmit halves toward the network.
  output logic                    tx_half_valid,
  input  wire logic               tx_half_ready,
  output hdp_pkg::hdp_half_t      tx_half_data,
  // Receive halves from the network.
  input  wire logic               rx_half_valid,
  output logic                    rx_half_ready,
  input  wire hdp_pkg::hdp_half_t rx_half_data
);
  import hdp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LATCH, ST_PUSH} hdp_dev_state_t;

  hdp_dev_state_t state_reg;
  logic           ack_reg, doe_reg;
  hdp_half_t      dout_reg;
  logic           wr_pend_reg, wr_half_reg;
  hdp_word_t      wr_stage_reg;
  hdp_word_t      commit_reg;
  hdp_idx_t       commit_idx_reg;
  logic           dw_wr_valid_reg, push_valid_reg;
  logic           rd_pend_reg, rd_half_reg, rd_hi_reg;
  hdp_word_t      rd_word_reg;
  hdp_idx_t       rd_idx_reg;
  logic           rd_req_reg;
  logic           rx_got_lo_reg, rx_full_reg;
  hdp_word_t      rx_word_reg;
  logic           rx_ready_reg, tx_sel_reg, tx_valid_reg;
  hdp_half_t      tx_data_reg;
  logic           swap_on, half_sel, this_hi;
  hdp_idx_t       acc_idx;
  logic           wr_hit, rd_hit, wr_pair, rx_take, rx_accept;
  logic           fifo_in_ready, fifo_out_valid, fifo_out_ready, tx_slot;
  hdp_word_t      fifo_out_data;

  // Any value but the exact pattern keeps the default mapping.
  assign swap_on  = (swap_ctrl == HDP_SWAP_PATTERN); // RQ9
  assign half_sel = hp.addr[HDP_HALF_BIT];
  // Physical half of the word that this access reaches.
  assign this_hi  = half_sel ^ swap_on; // RQ10
  assign acc_idx  = hp.addr[HDP_ADDR_W-1:HDP_HALF_BIT+1];

  // Strobes are honoured only while idle; the host waits for ack.
  assign wr_hit  = (state_reg == ST_IDLE) && !hp.cs_n && !hp.wr_n;
  assign rd_hit  = (state_reg == ST_IDLE) && !hp.cs_n && hp.wr_n && !hp.rd_n;
  assign wr_pair = wr_hit && wr_pend_reg && (half_sel != wr_half_reg); // RQ3
  assign rx_take = rd_hit && !rd_pend_reg && (acc_idx == HDP_RX_DATA_IDX);

  // Access sequencing and the answer on the data pins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      ack_reg   <= 1'b0;
      doe_reg   <= 1'b0;
      dout_reg  <= HDP_HALF_RST;
    end else begin
      ack_reg <= 1'b0;
      doe_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (wr_pair && (acc_idx == HDP_TX_DATA_IDX)) begin
            state_reg <= ST_PUSH;
          end else if (wr_hit) begin
            ack_reg <= 1'b1;
          end else if (rd_hit && rd_pend_reg) begin
            ack_reg <= 1'b1;
            doe_reg <= 1'b1;
            if (half_sel != rd_half_reg) begin
              dout_reg <= hdp_pick(rd_word_reg, this_hi); // RQ7
            end else begin
              dout_reg <= HDP_INVALID_HALF; // RQ8
            end
          end else if (rx_take) begin
            ack_reg  <= 1'b1;
            doe_reg  <= 1'b1;
            dout_reg <= hdp_pick(rx_full_reg ? rx_word_reg : HDP_WORD_RST, this_hi); // RQ11
          end else if (rd_hit) begin
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_reg <= ST_LATCH;
        end
        ST_LATCH: begin
          ack_reg   <= 1'b1;
          doe_reg   <= 1'b1;
          dout_reg  <= hdp_pick(dw_rd_data, rd_hi_reg); // RQ11
          state_reg <= ST_IDLE;
        end
        ST_PUSH: begin
          // A full transmit store holds ack back, stalling the host.
          if (push_valid_reg && fifo_in_ready) begin
            ack_reg   <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Write pairing: the first half waits in the staging word.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_reg    <= 1'b0;
      wr_half_reg    <= 1'b0;
      wr_stage_reg   <= HDP_WORD_RST;
      commit_reg     <= HDP_WORD_RST;
      commit_idx_reg <= HDP_IDX_RST;
    end else if (wr_hit) begin
      if (!wr_pend_reg) begin
        wr_pend_reg  <= 1'b1; // RQ13
        wr_half_reg  <= half_sel;
        wr_stage_reg <= hdp_place(HDP_WORD_RST, hp.bus_data, this_hi); // RQ9
      end else begin
        // A repeat of the pending half clears the pair and commits nothing.
        wr_pend_reg <= 1'b0; // RQ4
        if (wr_pair) begin
          commit_reg     <= hdp_place(wr_stage_reg, hp.bus_data, this_hi); // RQ13
          commit_idx_reg <= acc_idx;
        end
      end
    end
  end

  // Committed words go to the register port or the transmit store.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dw_wr_valid_reg <= 1'b0;
      push_valid_reg  <= 1'b0;
    end else begin
      dw_wr_valid_reg <= wr_pair && (acc_idx != HDP_TX_DATA_IDX);
      if (wr_pair && (acc_idx == HDP_TX_DATA_IDX)) begin
        push_valid_reg <= 1'b1;
      end else if (fifo_in_ready) begin
        push_valid_reg <= 1'b0;
      end
    end
  end

  // Read pairing; a broken pair leaves the next read as a fresh start.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
      rd_half_reg <= 1'b0;
      rd_hi_reg   <= 1'b0;
      rd_word_reg <= HDP_WORD_RST;
      rd_idx_reg  <= HDP_IDX_RST;
      rd_req_reg  <= 1'b0;
    end else begin
      rd_req_reg <= rd_hit && !rd_pend_reg && (acc_idx != HDP_RX_DATA_IDX);
      if (rd_hit) begin
        rd_pend_reg <= !rd_pend_reg; // RQ8
        if (!rd_pend_reg) begin
          rd_half_reg <= half_sel;
          rd_hi_reg   <= this_hi;
          rd_idx_reg  <= acc_idx;
          if (acc_idx == HDP_RX_DATA_IDX) begin
            rd_word_reg <= rx_full_reg ? rx_word_reg : HDP_WORD_RST;
          end
        end
      end else if (state_reg == ST_LATCH) begin
        rd_word_reg <= dw_rd_data;
      end
    end
  end

  // Receive assembly: the first half to arrive fills the low half.
  assign rx_accept = rx_half_valid && rx_ready_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_got_lo_reg <= 1'b0;
      rx_full_reg   <= 1'b0;
      rx_word_reg   <= HDP_WORD_RST;
      rx_ready_reg  <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_word_reg   <= hdp_place(rx_word_reg, rx_half_data, rx_got_lo_reg); // RQ12
        rx_got_lo_reg <= !rx_got_lo_reg;
        if (rx_got_lo_reg) rx_full_reg <= 1'b1;
      end else if (rx_take) begin
        rx_full_reg <= 1'b0;
      end
      // Only one word is held, so the network side waits until it is read.
      rx_ready_reg <= !((rx_full_reg && !rx_take) || (rx_accept && rx_got_lo_reg));
    end
  end

  // Transmit store between the host and the network side.
  hdp_fifo #(
    .WIDTH (HDP_WORD_W),
    .DEPTH (HDP_TX_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (commit_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Transmit split: low half first, the word leaves the store with its high half.
  assign tx_slot        = !tx_valid_reg || tx_half_ready;
  assign fifo_out_ready = tx_slot && tx_sel_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sel_reg   <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= HDP_HALF_RST;
    end else if (tx_slot) begin
      tx_valid_reg <= fifo_out_valid;
      if (fifo_out_valid) begin
        tx_data_reg <= hdp_pick(fifo_out_data, tx_sel_reg); // RQ12
        tx_sel_reg  <= !tx_sel_reg;
      end
    end
  end

  // Pins and user outputs straight from flip-flops.
  assign hp.ack         = ack_reg;
  assign hp.dev_data    = dout_reg;
  assign hp.dev_data_oe = doe_reg;
  assign dw_wr_valid    = dw_wr_valid_reg;
  assign dw_wr_idx      = commit_idx_reg;
  assign dw_wr_data     = commit_reg;
  assign dw_rd_req      = rd_req_reg;
  assign dw_rd_idx      = rd_idx_reg;
  assign tx_half_valid  = tx_valid_reg;
  assign tx_half_data   = tx_data_reg;
  assign rx_half_ready  = rx_ready_reg;
endmodule : hdp_device
`default_nettype wire

// ### rtl/hdp_host.sv
`timescale 1ns/1ps
`default_nettype none
module hdp_host (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Device pins.
  hdp_if.host_mp                  hp,
  // Command port.
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic               cmd_write,
  input  wire logic               cmd_hi_first,
  input  wire hdp_pkg::hdp_idx_t  cmd_idx,
  input  wire hdp_pkg::hdp_word_t cmd_wdata,
  // Answer port.
  output logic                    rsp_valid,
  output hdp_pkg::hdp_word_t      rsp_rdata
);
  import hdp_pkg::*;

  typedef enum logic {HS_IDLE, HS_WAIT} hdp_host_state_t;

  hdp_host_state_t state_reg;
  logic            second_reg, half_reg, write_reg;
  hdp_idx_t        idx_reg;
  hdp_word_t       wdata_reg;
  hdp_word_t       rdata_reg;
  logic            ready_reg, rsp_valid_reg, cs_n_reg, wr_n_reg, rd_n_reg;
  hdp_addr_t       addr_reg;
  hdp_half_t       hdata_reg;
  logic            hoe_reg;
  logic            start, next_half;

  assign start     = (state_reg == HS_IDLE) && cmd_valid && ready_reg;
  assign next_half = (state_reg == HS_WAIT) && hp.ack && !second_reg;

  // One-cycle strobes; the second half follows the first ack at once.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_n_reg  <= 1'b1;
      wr_n_reg  <= 1'b1;
      rd_n_reg  <= 1'b1;
      addr_reg  <= HDP_ADDR_RST;
      hdata_reg <= HDP_HALF_RST;
      hoe_reg   <= 1'b0;
    end else begin
      cs_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      hoe_reg  <= 1'b0;
      if (start) begin
        cs_n_reg  <= 1'b0; // RQ1 RQ5
        wr_n_reg  <= !cmd_write;
        rd_n_reg  <= cmd_write;
        addr_reg  <= {cmd_idx, cmd_hi_first, 1'b0};
        hdata_reg <= hdp_pick(cmd_wdata, cmd_hi_first);
        hoe_reg   <= cmd_write;
      end else if (next_half) begin
        // Same word index, other half only.
        cs_n_reg  <= 1'b0; // RQ2 RQ6
        wr_n_reg  <= !write_reg;
        rd_n_reg  <= write_reg;
        addr_reg  <= {idx_reg, !half_reg, 1'b0};
        hdata_reg <= hdp_pick(wdata_reg, !half_reg);
        hoe_reg   <= write_reg;
      end
    end
  end

  // Command tracking and read data assembly.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= HS_IDLE;
      second_reg    <= 1'b0;
      half_reg      <= 1'b0;
      write_reg     <= 1'b0;
      idx_reg       <= HDP_IDX_RST;
      wdata_reg     <= HDP_WORD_RST;
      rdata_reg     <= HDP_WORD_RST;
      ready_reg     <= 1'b1;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          if (start) begin
            state_reg  <= HS_WAIT;
            ready_reg  <= 1'b0;
            second_reg <= 1'b0;
            half_reg   <= cmd_hi_first;
            write_reg  <= cmd_write;
            idx_reg    <= cmd_idx;
            wdata_reg  <= cmd_wdata;
          end
        end
        HS_WAIT: begin
          if (hp.ack) begin
            if (!write_reg) rdata_reg <= hdp_place(rdata_reg, hp.bus_data, half_reg);
            if (second_reg) begin
              state_reg     <= HS_IDLE;
              ready_reg     <= 1'b1;
              rsp_valid_reg <= 1'b1;
            end else begin
              second_reg <= 1'b1;
              half_reg   <= !half_reg;
            end
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  // Pins and user outputs straight from flip-flops.
  assign hp.cs_n         = cs_n_reg;
  assign hp.wr_n         = wr_n_reg;
  assign hp.rd_n         = rd_n_reg;
  assign hp.addr         = addr_reg;
  assign hp.host_data    = hdata_reg;
  assign hp.host_data_oe = hoe_reg;
  assign cmd_ready       = ready_reg;
  assign rsp_valid       = rsp_valid_reg;
  assign rsp_rdata       = rdata_reg;
endmodule : hdp_host
`default_nettype wire

// ### verif/hdp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hdp_chk (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Host pins of the joined interface.
  input  wire logic               cs_n,
  input  wire logic               wr_n,
  input  wire logic               rd_n,
  input  wire hdp_pkg::hdp_addr_t addr,
  input  wire logic               host_data_oe,
  input  wire logic               dev_data_oe,
  input  wire logic               ack
);
  import hdp_pkg::*;
  logic      odd_reg;
  logic      wr1_reg;
  hdp_addr_t a1_reg;
  wire       stb_wr = !cs_n && !wr_n;
  wire       stb_rd = !cs_n && wr_n && !rd_n;

  // Pair tracker; the host strobes only an idle device.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      odd_reg <= 1'b0;
      wr1_reg <= 1'b0;
      a1_reg  <= HDP_ADDR_RST;
    end else if (!cs_n) begin
      odd_reg <= !odd_reg;
      wr1_reg <= !wr_n;
      a1_reg  <= addr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_wr_second;
    ack && odd_reg && wr1_reg |=> stb_wr;
  endproperty
  a_wr_second: assert property (p_wr_second)
    else $error("no second write half after the answer");
  property p_wr_addr;
    stb_wr && odd_reg |-> wr1_reg && addr[7:2] == a1_reg[7:2] && addr[1] != a1_reg[1];
  endproperty
  a_wr_addr: assert property (p_wr_addr)
    else $error("write halves do not share one word");
  property p_rd_second;
    ack && odd_reg && !wr1_reg |=> stb_rd;
  endproperty
  a_rd_second: assert property (p_rd_second)
    else $error("no second read half after the answer");
  property p_rd_addr;
    stb_rd && odd_reg |-> !wr1_reg && addr[7:2] == a1_reg[7:2] && addr[1] != a1_reg[1];
  endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("read halves do not share one word");
  property p_wr_ack;
    stb_wr && addr[7:2] != HDP_TX_DATA_IDX |=> ack && !dev_data_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write half not answered next cycle");
  property p_rd_pair;
    stb_rd && odd_reg |=> ack && dev_data_oe;
  endproperty
  a_rd_pair: assert property (p_rd_pair)
    else $error("second read half not answered next cycle");
  property p_rd_fresh;
    stb_rd && !odd_reg && addr[7:2] != HDP_RX_DATA_IDX |=> !ack ##1 !ack ##1 ack && dev_data_oe;
  endproperty
  a_rd_fresh: assert property (p_rd_fresh)
    else $error("fresh read not answered in three cycles");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("answer held longer than one cycle");
  property p_bus_owner;
    (dev_data_oe |-> ack && !host_data_oe) and (host_data_oe |-> stb_wr);
  endproperty
  a_bus_owner: assert property (p_bus_owner)
    else $error("data bus driven outside its transfer");
endmodule : hdp_chk
`default_nettype wire

// ### verif/host_dword_port_word_swap_test.sv
`timescale 1ns/1ps
`default_nettype none
module host_dword_port_word_swap_test;
  import hdp_pkg::*;
  // Clock, reset, command side and the user side of the first device.
  logic      clk, sys_rst, cmd_valid, cmd_ready, cmd_write, cmd_hi_first, rsp_valid;
  logic      dw_wr_valid, dw_rd_req, wr_valid2, ok;
  logic      tx_half_valid, tx_half_ready, rx_half_valid, rx_half_ready;
  hdp_idx_t  cmd_idx, dw_wr_idx, dw_rd_idx, wr_idx2, rd_idx2;
  hdp_word_t cmd_wdata, rsp_rdata, swap_ctrl, dw_wr_data, dw_rd_data, wr_data2, rd_data2;
  hdp_word_t last_wr, wd, regs [64];
  hdp_half_t tx_half_data, rx_half_data, txq [$];
  int        fails = 0, n_checks = 0, wr2_cnt = 0, n;

  hdp_if u_hdp_if ();
  hdp_if u_hdp_if2 ();
  hdp_host u_hdp_host (.clk(clk), .sys_rst(sys_rst), .hp(u_hdp_if.host_mp),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_hi_first(cmd_hi_first), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hdp_device u_hdp_device (.clk(clk), .sys_rst(sys_rst), .hp(u_hdp_if.dev_mp),
    .swap_ctrl(swap_ctrl), .dw_wr_valid(dw_wr_valid), .dw_wr_idx(dw_wr_idx),
    .dw_wr_data(dw_wr_data), .dw_rd_req(dw_rd_req), .dw_rd_idx(dw_rd_idx),
    .dw_rd_data(dw_rd_data), .tx_half_valid(tx_half_valid), .tx_half_ready(tx_half_ready),
    .tx_half_data(tx_half_data), .rx_half_valid(rx_half_valid),
    .rx_half_ready(rx_half_ready), .rx_half_data(rx_half_data));
  // Second device is strobed pin by pin to break pairs on purpose.
  hdp_device u_hdp_device2 (.clk(clk), .sys_rst(sys_rst), .hp(u_hdp_if2.dev_mp),
    .swap_ctrl(32'h00000000), .dw_wr_valid(wr_valid2), .dw_wr_idx(wr_idx2),
    .dw_wr_data(wr_data2), .dw_rd_req(), .dw_rd_idx(rd_idx2), .dw_rd_data(rd_data2),
    .tx_half_valid(), .tx_half_ready(1'b1), .tx_half_data(), .rx_half_valid(1'b0),
    .rx_half_ready(), .rx_half_data(16'h0000));
  hdp_chk u_hdp_chk (.clk(clk), .sys_rst(sys_rst), .cs_n(u_hdp_if.cs_n),
    .wr_n(u_hdp_if.wr_n), .rd_n(u_hdp_if.rd_n), .addr(u_hdp_if.addr),
    .host_data_oe(u_hdp_if.host_data_oe), .dev_data_oe(u_hdp_if.dev_data_oe),
    .ack(u_hdp_if.ack));

  // Register file shared by both devices; reads are combinational.
  assign dw_rd_data = regs[dw_rd_idx];
  assign rd_data2   = regs[rd_idx2];

  // Commits land in the register file; transmitted halves are queued in order.
  always @(posedge clk) begin
    if (dw_wr_valid === 1'b1) begin
      regs[dw_wr_idx] <= dw_wr_data;
      last_wr         <= dw_wr_data;
    end
    if (wr_valid2 === 1'b1) begin
      regs[wr_idx2] <= wr_data2;
      wr2_cnt       <= wr2_cnt + 1;
    end
    if (tx_half_valid && tx_half_ready)
      txq.push_back(tx_half_data);
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input hdp_word_t got, input hdp_word_t exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Polls mid-cycle, where the one-cycle answer pulse is settled.
  task automatic wait_rsp(input int lim, output logic res);
    res = 1'b0;
    for (int i = 0; i < lim && !res; i++) begin
      @(negedge clk);
      res = (rsp_valid === 1'b1);
    end
  endtask : wait_rsp

  task automatic cmd(input logic w, input logic hi, input hdp_idx_t idx,
                     input hdp_word_t d, input int lim, output logic res);
    {cmd_write, cmd_hi_first, cmd_idx, cmd_wdata} = {w, hi, idx, d};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_rsp(lim, res);
  endtask : cmd

  task automatic xfer(input logic w, input hdp_idx_t idx, input hdp_word_t d, input logic hi);
    cmd(w, hi, idx, d, 40, ok);
    chk(32'(ok), 32'h1);
    if (!w)
      chk(rsp_rdata, d);
  endtask : xfer

  // One strobe on the second interface; the answer is taken while ack stands.
  task automatic pin(input logic w, input hdp_addr_t a, input hdp_half_t d, input hdp_half_t e);
    {u_hdp_if2.cs_n, u_hdp_if2.wr_n, u_hdp_if2.rd_n} = {1'b0, !w, w};
    {u_hdp_if2.addr, u_hdp_if2.host_data, u_hdp_if2.host_data_oe} = {a, d, w};
    @(negedge clk);
    {u_hdp_if2.cs_n, u_hdp_if2.wr_n, u_hdp_if2.rd_n, u_hdp_if2.host_data_oe} = 4'hE;
    for (int i = 0; i < 20 && u_hdp_if2.ack !== 1'b1; i++)
      @(negedge clk);
    chk(32'(u_hdp_if2.ack), 32'h1);
    if (!w)
      chk({16'h0000, u_hdp_if2.bus_data}, {16'h0000, e});
    @(negedge clk);
  endtask : pin

  task automatic rxput(input hdp_half_t h);
    {rx_half_valid, rx_half_data} = {1'b1, h};
    for (int i = 0; i < 20 && rx_half_ready !== 1'b1; i++)
      @(negedge clk);
    @(negedge clk);
  endtask : rxput

  task automatic conclude();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    {sys_rst, cmd_valid, cmd_write, cmd_hi_first, cmd_idx, cmd_wdata} = {1'b1, 41'h0};
    {swap_ctrl, tx_half_ready, rx_half_valid, rx_half_data} = {32'h0, 1'b1, 17'h0};
    {u_hdp_if2.cs_n, u_hdp_if2.wr_n, u_hdp_if2.rd_n, u_hdp_if2.host_data_oe} = 4'hE;
    {u_hdp_if2.addr, u_hdp_if2.host_data} = 24'h0;
    foreach (regs[i])
      regs[i] = 32'h00000000;
    regs[12] = 32'hBEEF_F00D;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    // Default, swap pattern and an all-ones value; both half orders are used.
    for (int k = 0; k < 3; k++) begin
      swap_ctrl = (k == 1) ? HDP_SWAP_PATTERN : {32{k[1]}};
      wd = 32'h1357_9BD0 + k;
      xfer(1'b1, 6'(5 + k), wd, k[0]);
      chk(last_wr, (k == 1) ? {wd[15:0], wd[31:16]} : wd);
      xfer(1'b0, 6'(5 + k), wd, !k[0]);
    end
    // Receive words: first half lands low, read back through either mapping.
    for (int k = 0; k < 2; k++) begin
      swap_ctrl = k[0] ? HDP_SWAP_PATTERN : 32'h00000000;
      rxput(16'h0C0D);
      rxput(16'hA0B0);
      rx_half_valid = 1'b0;
      xfer(1'b0, HDP_RX_DATA_IDX, k[0] ? 32'h0C0D_A0B0 : 32'hA0B0_0C0D, 1'b0);
    end
    // Stall the network side until the transmit buffer refuses, then drain it.
    swap_ctrl = 32'h00000000;
    tx_half_ready = 1'b0;
    txq.delete();
    ok = 1'b1;
    for (n = 0; n < 24 && ok; n++)
      cmd(1'b1, 1'b0, HDP_TX_DATA_IDX, 32'hB000_A000 + 32'h0001_0001 * n, 30, ok);
    chk(32'(ok), 32'h0);
    chk(32'(n), 32'(HDP_TX_DEPTH + 1));
    tx_half_ready = 1'b1;
    wait_rsp(100, ok);
    chk(32'(ok), 32'h1);
    for (int i = 0; i < 300 && txq.size() < 2 * n; i++)
      @(negedge clk);
    chk(32'(txq.size()), 32'(2 * n));
    for (int j = 0; j < n; j++) begin
      chk({16'h0000, txq[2 * j]}, 32'h0000_A000 + j);
      chk({16'h0000, txq[2 * j + 1]}, 32'h0000_B000 + j);
    end
    // Swapped transmit write: the host's high half becomes the first half out.
    swap_ctrl = HDP_SWAP_PATTERN;
    txq.delete();
    xfer(1'b1, HDP_TX_DATA_IDX, 32'h1111_2222, 1'b0);
    for (int i = 0; i < 20 && txq.size() < 2; i++)
      @(negedge clk);
    chk({txq[0], txq[1]}, 32'h1111_2222);
    // A repeated write half drops the pair; the next two form a fresh word.
    n = wr2_cnt;
    pin(1'b1, 8'h28, 16'h1111, 16'h0000);
    pin(1'b1, 8'h28, 16'h2222, 16'h0000);
    chk(32'(wr2_cnt - n), 32'h0);
    pin(1'b1, 8'h2A, 16'h3333, 16'h0000);
    pin(1'b1, 8'h28, 16'h4444, 16'h0000);
    chk(32'(wr2_cnt - n), 32'h1);
    chk(regs[10], 32'h3333_4444);
    // A repeated read half answers invalid data, then pairing starts afresh.
    pin(1'b0, 8'h30, 16'h0000, 16'hF00D);
    pin(1'b0, 8'h30, 16'h0000, HDP_INVALID_HALF);
    pin(1'b0, 8'h32, 16'h0000, 16'hBEEF);
    pin(1'b0, 8'h30, 16'h0000, 16'hF00D);
    conclude();
  end

  // Watchdog well beyond the few hundred cycles needed.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule : host_dword_port_word_swap_test
`default_nettype wire
